// ===== xcbt_consts.svh
// Purpose: Constants for the XOR chain board test block
// Assumes: Included by bare name from the package and the top module
// Notes:   Definitions only; chain lengths are defaults of parameters
//
// Behaviour
// - Testable input pins form seven separate XOR chains, one result each.
// - Each gate XORs one input pin with the previous gate's plain output.
// - First gate's previous input is tied to one; last output is result.
// - Even count of inputs at one gives result 1, odd gives 0.
// - Raising inputs one by one along a chain toggles its result.
// - Tri-state strap high at reset release floats every output.
// - XOR strap high with tri-state strap low at reset release enables chains 1, 2, 4 to 7.
// - Chains 1, 2, 4 to 7 and tri-state need no clock.
// - Chain 1 is odd; all inputs at one read result 0.
// - Chain 3 is even; all inputs at one read result 1.
`ifndef XCBT_CONSTS_SVH
`define XCBT_CONSTS_SVH

// ----------------------------------------
// Chain structure
// ----------------------------------------
`define XCBT_NUM_CHAINS 7
`define XCBT_LEN_C1 9
`define XCBT_LEN_C2 8
`define XCBT_LEN_C3 16
`define XCBT_LEN_C4 10
`define XCBT_LEN_C5 9
`define XCBT_LEN_C6 11
`define XCBT_LEN_C7 7
`define XCBT_C3_IDX 2
`define XCBT_NUM_OUT 16

// ----------------------------------------
// Chain 3 initialisation timing
// ----------------------------------------
`define XCBT_C3_INIT_CYC 35000
`define XCBT_CNT_W 16
`define XCBT_CNT_ZERO 16'h0000

`endif

// ===== xcbt_pkg.sv
// Purpose: Types for the XOR chain board test block
// Assumes: Constants come from xcbt_consts.svh
// Notes:   Types only
`include "xcbt_consts.svh"

package xcbt_pkg;

    // ----------------------------------------
    // Chain 3 initialisation states
    // ----------------------------------------
    typedef enum logic [2:0] {
        XCBT_C3_IDLE  = 3'h1,
        XCBT_C3_WAIT  = 3'h2,
        XCBT_C3_READY = 3'h4
    } xcbt_c3_t;

    // Clocked state of the block
    typedef struct packed {
        xcbt_c3_t c3;
        logic [`XCBT_CNT_W-1:0] cnt;
    } xcbt_state_t;

    // Straps caught at reset release
    typedef struct packed {
        logic tri_sel;
        logic xor_sel;
    } xcbt_strap_t;

    // Output pin bundle, enable active low
    typedef struct packed {
        logic [`XCBT_NUM_OUT-1:0] out;
        logic [`XCBT_NUM_OUT-1:0] oe_n;
    } xcbt_pins_t;

endpackage

// ===== xcbt_top.sv
// Purpose: XOR chain board test logic with strap-selected test modes
// Assumes: clk stands for the hub link clock during chain 3 set-up
// Notes:   Chain paths are combinational so most modes run clockless
`timescale 1ns/1ps
`default_nettype none
`include "xcbt_consts.svh"

module xcbt_top #(
    parameter int C3_INIT_CYC = `XCBT_C3_INIT_CYC,
    parameter int LEN_C1 = `XCBT_LEN_C1,
    parameter int LEN_C2 = `XCBT_LEN_C2,
    parameter int LEN_C3 = `XCBT_LEN_C3,
    parameter int LEN_C4 = `XCBT_LEN_C4,
    parameter int LEN_C5 = `XCBT_LEN_C5,
    parameter int LEN_C6 = `XCBT_LEN_C6,
    parameter int LEN_C7 = `XCBT_LEN_C7,
    parameter int TOTAL = LEN_C1 + LEN_C2 + LEN_C3 + LEN_C4
                        + LEN_C5 + LEN_C6 + LEN_C7
) (
    input wire logic clk, // Hub link clock
    input wire logic arst_n, // System reset, active low
    input wire logic tristate_strap_pin, // Float-all strap
    input wire logic xor_mode_strap_pin, // XOR test strap
    input wire logic [TOTAL-1:0] chain_in, // Pin inputs, chain 1 at bit 0
    input wire xcbt_pkg::xcbt_pins_t core_pins, // Functional drive
    output xcbt_pkg::xcbt_pins_t pins, // Pin drive, enable low
    output logic [`XCBT_NUM_CHAINS-1:0] chain_result, // Chain outputs
    output logic tri_mode, // Float-all mode active
    output logic xor_mode, // XOR test mode active
    output logic c3_ready // Chain 3 initialised
);
    import xcbt_pkg::*;

    // ----------------------------------------
    // Chain geometry
    // ----------------------------------------
    localparam int NC = `XCBT_NUM_CHAINS;
    localparam int LENS [NC] = '{LEN_C1, LEN_C2, LEN_C3, LEN_C4,
                                 LEN_C5, LEN_C6, LEN_C7};
    localparam int C3 = `XCBT_C3_IDX;

    // Start bit of chain k in chain_in
    function automatic int chain_off(input int k);
        int s;
        s = 0;
        for (int i = 0; i < k; i++) begin
            s = s + LENS[i];
        end
        return s;
    endfunction

    // ----------------------------------------
    // XOR chains
    // ----------------------------------------
    logic [TOTAL-1:0] stage;

    // One gate per pin, strictly serial so each stage is observable
    genvar gk, gj;
    generate
        for (gk = 0; gk < NC; gk++) begin : g_chain
            localparam int OFF = chain_off(gk);
            for (gj = 0; gj < LENS[gk]; gj++) begin : g_gate
                if (gj == 0) begin : g_first
                    // First gate sees a constant one upstream
                    assign stage[OFF] = 1'b1 ^ chain_in[OFF];
                end else begin : g_next
                    // Plain output of previous gate feeds this one
                    assign stage[OFF+gj] =
                        stage[OFF+gj-1] ^ chain_in[OFF+gj];
                end
            end
            // Last gate is the chain's observable output
            assign chain_result[gk] =
                stage[OFF+LENS[gk]-1];
        end
    endgenerate

    // ----------------------------------------
    // Strap capture
    // ----------------------------------------
    xcbt_strap_t strap_reg;

    // Caught on the reset release edge itself: no clock may be running
    always_ff @(posedge arst_n) begin
        strap_reg.tri_sel <= tristate_strap_pin;
        strap_reg.xor_sel <= xor_mode_strap_pin;
    end

    // Modes only count outside reset; float-all wins over XOR
    assign tri_mode = arst_n & strap_reg.tri_sel;
    assign xor_mode = arst_n & ~strap_reg.tri_sel
                      & strap_reg.xor_sel;

    // ----------------------------------------
    // Chain 3 initialisation counter
    // ----------------------------------------
    xcbt_state_t state_reg;
    xcbt_state_t state_next;
    logic cnt_done;

    assign cnt_done =
        (state_reg.cnt == `XCBT_CNT_W'(C3_INIT_CYC - 1));

    // Counts link clocks after release before chain 3 is trusted
    always_comb begin
        state_next = state_reg;
        case (state_reg.c3)
            XCBT_C3_IDLE: begin
                if (xor_mode) begin
                    state_next.c3 = XCBT_C3_WAIT;
                    state_next.cnt = `XCBT_CNT_ZERO;
                end
            end
            XCBT_C3_WAIT: begin
                if (cnt_done) begin
                    state_next.c3 = XCBT_C3_READY;
                end else begin
                    state_next.cnt = `XCBT_CNT_W'(state_reg.cnt + 1'b1);
                end
            end
            XCBT_C3_READY: begin
                state_next.c3 = XCBT_C3_READY;
            end
            default: begin
                state_next.c3 = XCBT_C3_IDLE;
                state_next.cnt = `XCBT_CNT_ZERO;
            end
        endcase
    end

    // State register, cleared by reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg.c3 <= XCBT_C3_IDLE;
            state_reg.cnt <= `XCBT_CNT_ZERO;
        end else begin
            state_reg <= state_next;
        end
    end

    assign c3_ready = (state_reg.c3 == XCBT_C3_READY);

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    // Result pins borrow the first outputs; chain 3 waits for set-up
    always_comb begin
        pins = core_pins;
        if (tri_mode) begin
            pins.oe_n = '1;
        end else if (xor_mode) begin
            for (int i = 0; i < NC; i++) begin
                if (i != C3 || c3_ready) begin
                    pins.out[i] = chain_result[i];
                    pins.oe_n[i] = 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [NC-1:0] exp_res;
    logic c1_all_one;
    logic c3_all_one;

    // Parity reference, independent of the gate chain
    always_comb begin
        for (int k = 0; k < NC; k++) begin
            exp_res[k] = 1'b1;
            for (int j = 0; j < TOTAL; j++) begin
                if (j >= chain_off(k) && j < chain_off(k) + LENS[k]) begin
                    exp_res[k] = exp_res[k] ^ chain_in[j];
                end
            end
        end
    end

    assign c1_all_one = &chain_in[LEN_C1-1:0];
    assign c3_all_one = &chain_in[chain_off(C3) +: LEN_C3];

    // One pin changes either way, so one result flips
    sequence s_one_step;
        $onehot(chain_in ^ $past(chain_in));
    endsequence

    sequence s_one_flip;
        $onehot(chain_result ^ $past(chain_result));
    endsequence

    property p_parity;
        @(posedge clk) disable iff (!arst_n)
        chain_result == exp_res;
    endproperty
    a_parity: assert property (p_parity)
        else $error("chain result disagrees with input parity");

    property p_all_zero;
        @(posedge clk) disable iff (!arst_n)
        (chain_in == '0) |-> (chain_result == '1);
    endproperty
    a_all_zero: assert property (p_all_zero)
        else $error("all-zero inputs must give all ones");

    property p_toggle;
        @(posedge clk) disable iff (!arst_n)
        s_one_step |-> s_one_flip;
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("single input step did not toggle one result");

    property p_c1_ones;
        @(posedge clk) disable iff (!arst_n)
        c1_all_one |-> (chain_result[0] == ~LEN_C1[0]);
    endproperty
    a_c1_ones: assert property (p_c1_ones)
        else $error("chain 1 all ones gives wrong result");

    property p_c3_ones;
        @(posedge clk) disable iff (!arst_n)
        c3_all_one |-> (chain_result[C3] == ~LEN_C3[0]);
    endproperty
    a_c3_ones: assert property (p_c3_ones)
        else $error("chain 3 all ones gives wrong result");

    property p_float;
        @(posedge clk) disable iff (!arst_n)
        tri_mode |-> (pins.oe_n == '1) && !xor_mode;
    endproperty
    a_float: assert property (p_float)
        else $error("output driven in float-all mode");

    property p_xor_pin;
        @(posedge clk) disable iff (!arst_n)
        xor_mode |-> (pins.out[0] == chain_result[0])
                     && !pins.oe_n[0];
    endproperty
    a_xor_pin: assert property (p_xor_pin)
        else $error("chain 1 result not on its pin in XOR mode");

    property p_latch;
        @(posedge clk) disable iff (!arst_n)
        $past(arst_n) |-> $stable(tri_mode) && $stable(xor_mode);
    endproperty
    a_latch: assert property (p_latch)
        else $error("test mode changed without a reset");

    property p_c3_wait;
        @(posedge clk) disable iff (!arst_n)
        (state_reg.c3 == XCBT_C3_WAIT) && !cnt_done
            |=> !c3_ready && (state_reg.cnt == $past(state_reg.cnt) + 1);
    endproperty
    a_c3_wait: assert property (p_c3_wait)
        else $error("chain 3 ready before set-up count ends");

    property p_c3_hold;
        @(posedge clk) disable iff (!arst_n)
        xor_mode && !c3_ready |-> pins.out[C3] == core_pins.out[C3];
    endproperty
    a_c3_hold: assert property (p_c3_hold)
        else $error("chain 3 pin taken before set-up done");

    property p_tri_out;
        @(posedge clk) disable iff (!arst_n)
        tri_mode |-> (pins.out == core_pins.out);
    endproperty
    a_tri_out: assert property (p_tri_out)
        else $error("float-all mode altered output values");

    property p_c3_pin;
        @(posedge clk) disable iff (!arst_n)
        xor_mode && c3_ready |-> (pins.out[C3] == chain_result[C3])
                                 && !pins.oe_n[C3];
    endproperty
    a_c3_pin: assert property (p_c3_pin)
        else $error("chain 3 result missing from its pin once ready");

    property p_c3_done;
        @(posedge clk) disable iff (!arst_n)
        (state_reg.c3 == XCBT_C3_WAIT) && cnt_done |=> c3_ready;
    endproperty
    a_c3_done: assert property (p_c3_done)
        else $error("chain 3 not ready after set-up count");

    property p_no_count;
        @(posedge clk) disable iff (!arst_n)
        !xor_mode |=> (state_reg.c3 == XCBT_C3_IDLE);
    endproperty
    a_no_count: assert property (p_no_count)
        else $error("chain 3 counter ran outside XOR mode");

    property p_ready_hold;
        @(posedge clk) disable iff (!arst_n)
        c3_ready |=> c3_ready;
    endproperty
    a_ready_hold: assert property (p_ready_hold)
        else $error("chain 3 ready dropped without a reset");

    property p_in_reset;
        @(posedge clk)
        !arst_n |-> (pins == core_pins) && !tri_mode && !xor_mode;
    endproperty
    a_in_reset: assert property (p_in_reset)
        else $error("test mode active while reset is held");

endmodule
`default_nettype wire

// ===== xcbt_ate.sv
// Purpose: Board tester model driving reset, straps and chain pins
// Assumes: Caller paces drive(); mode entry is paced on clk falling edges
// Notes:   Strobe pair is forced complementary whatever pattern is asked
`timescale 1ns/1ps
`default_nettype none

module xcbt_ate #(
    parameter int TOTAL = 70,
    parameter int RST_LOW = 3, // Link clocks that reset is held low
    parameter int STRB_T = 69, // Hub strobe true bit, in chain 7
    parameter int STRB_C = 62 // Hub strobe comp bit, in chain 6
) (
    input wire logic clk, // Pacing clock
    output logic arst_n, // System reset drive
    output logic tristate_strap_pin, // Float-all strap drive
    output logic xor_mode_strap_pin, // XOR strap drive
    output logic [TOTAL-1:0] chain_in // Chain pin drive
);
    // ----------------------------------------
    // Power-on levels
    // ----------------------------------------
    initial begin
        arst_n = 1'b0;
        tristate_strap_pin = 1'b0;
        xor_mode_strap_pin = 1'b0;
        chain_in = '0;
    end

    // Strap high, reset high, pulse low, release, then drop straps
    task automatic enter(input logic tri_s, input logic xor_s);
        tristate_strap_pin = tri_s;
        xor_mode_strap_pin = xor_s;
        arst_n = 1'b1;
        @(negedge clk);
        arst_n = 1'b0;
        repeat (RST_LOW) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        // Straps drop: the XOR strap doubles as a chain 2 pin
        tristate_strap_pin = 1'b0;
        xor_mode_strap_pin = 1'b0;
    endtask

    // Pattern drive; a real tester may never drive the strobes alike
    task automatic drive(input logic [TOTAL-1:0] v);
        logic [TOTAL-1:0] t;
        t = v;
        t[STRB_C] = ~t[STRB_T];
        chain_in = t;
    endtask
endmodule

`default_nettype wire

// ===== xor_chain_board_test_test.sv
// Purpose: Self-checking bench for the XOR chain board test block
// Assumes: Chain lengths at their defaults; chain 3 count shortened
// Notes:   Expected chain results come from a bench parity model
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("MISMATCH %s exp=%h got=%h", what, e, g); \
    end \
end

module xor_chain_board_test_test;
    import xcbt_pkg::*;
    localparam int C3 = 8;
    localparam int T = 70;
    localparam int LEN [7] = '{9, 8, 16, 10, 9, 11, 7};
    logic clk = 1'b0;
    logic clk_run = 1'b1;
    wire logic arst_n;
    wire logic tri_s;
    wire logic xor_s;
    wire logic [T-1:0] chain_in;
    xcbt_pins_t core_pins;
    xcbt_pins_t pins;
    logic [6:0] chain_result;
    logic tri_mode;
    logic xor_mode;
    logic c3_ready;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'h00014A60;
    logic [T-1:0] v;

    // ----------------------------------------
    // Clock, stoppable to prove clockless paths
    // ----------------------------------------
    // 100 MHz link clock; a host clock would simply run inverted
    always #5 clk = clk_run ? ~clk : clk;

    xcbt_ate #(.TOTAL(T), .RST_LOW(C3)) ate_u (.clk(clk),
        .arst_n(arst_n), .tristate_strap_pin(tri_s),
        .xor_mode_strap_pin(xor_s), .chain_in(chain_in));

    xcbt_top #(.C3_INIT_CYC(C3)) dut_u (.clk(clk), .arst_n(arst_n),
        .tristate_strap_pin(tri_s), .xor_mode_strap_pin(xor_s),
        .chain_in(chain_in), .core_pins(core_pins), .pins(pins),
        .chain_result(chain_result), .tri_mode(tri_mode),
        .xor_mode(xor_mode), .c3_ready(c3_ready));

    // ----------------------------------------
    // Models and helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Parity per chain, seeded with one at the first gate
    function automatic logic [6:0] exp_res(input logic [T-1:0] x);
        int b;
        logic [6:0] r;
        b = 0;
        for (int k = 0; k < 7; k++) begin
            r[k] = 1'b1;
            for (int i = 0; i < LEN[k]; i++) begin
                r[k] ^= x[b];
                b++;
            end
        end
        return r;
    endfunction

    task automatic apply(input logic [T-1:0] x);
        logic [6:0] e;
        ate_u.drive(x);
        #1;
        e = exp_res(ate_u.chain_in);
        `CHK("chain_result", e, chain_result)
    endtask

    // Result pins carry chains in XOR mode; pin 2 only once ready
    task automatic chk_pins(input logic [6:0] e, input logic rdy);
        logic [15:0] m;
        logic [15:0] eo;
        m = rdy ? 16'h007F : 16'h007B;
        eo = (core_pins.out & ~m) | ({9'h000, e} & m);
        `CHK("pins_out", eo, pins.out)
        `CHK("pins_oe_n", core_pins.oe_n & ~m, pins.oe_n)
    endtask

    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        core_pins = xcbt_pins_t'(32'hA5C30F0F);
        repeat (3) @(negedge clk);
        `CHK("tri_mode", 1'b0, tri_mode)
        `CHK("pins_in_reset", core_pins, pins)
        ate_u.enter(1'b1, 1'b0);
        `CHK("tri_mode", 1'b1, tri_mode)
        `CHK("xor_mode", 1'b0, xor_mode)
        `CHK("oe_n_float", 16'hFFFF, pins.oe_n)
        $display("test tri_state done");
        // Tri strap wins, and chain 3 never counts up
        ate_u.enter(1'b1, 1'b1);
        repeat (C3 + 2) @(negedge clk);
        `CHK("xor_mode", 1'b0, xor_mode)
        `CHK("c3_ready", 1'b0, c3_ready)
        $display("test strap_priority done");
        ate_u.enter(1'b0, 1'b1);
        `CHK("xor_mode", 1'b1, xor_mode)
        `CHK("tri_mode", 1'b0, tri_mode)
        repeat (C3 - 1) @(negedge clk);
        `CHK("c3_ready", 1'b0, c3_ready)
        chk_pins(exp_res(chain_in), 1'b0);
        @(negedge clk);
        `CHK("c3_ready", 1'b1, c3_ready)
        $display("test chain3_init done");
        // Clock halted: chain results must still follow the pins
        clk_run = 1'b0;
        v = '0;
        apply(v);
        // Strobe pair forces the chain 6 comp pin high: one odd chain
        `CHK("all_zero", 7'h5F, chain_result)
        for (int i = 0; i < LEN[0]; i++) begin
            v[i] = 1'b1;
            apply(v);
            `CHK("toggle", 1'(i % 2), chain_result[0])
        end
        `CHK("c1_all_one", 1'b0, chain_result[0])
        clk_run = 1'b1;
        $display("test clockless_walk done");
        @(negedge clk);
        apply('1);
        `CHK("c3_all_one", 1'b1, chain_result[2])
        chk_pins(exp_res(chain_in), 1'b1);
        // Clocked walk down chain 3 so the step check sees single flips
        for (int i = 17; i < 33; i++) begin
            @(negedge clk);
            v = ate_u.chain_in;
            v[i] = 1'b0;
            apply(v);
            `CHK("toggle_c3", 1'((i - 15) % 2), chain_result[2])
        end
        repeat (40) begin
            @(negedge clk);
            core_pins = xcbt_pins_t'(rnd());
            v = T'({rnd(), rnd(), rnd()});
            apply(v);
            chk_pins(exp_res(chain_in), 1'b1);
        end
        `CHK("xor_mode", 1'b1, xor_mode)
        $display("test random_patterns done");
        test_done();
    end

    // Watchdog well beyond the roughly 110 cycles needed
    initial begin
        #(3000 * 10);
        n_mismatch++;
        test_done();
    end
endmodule

`default_nettype wire
